// ### rtl/identify_pkg.sv
// Constants, field layouts and types for the identify feature words.
// Assumes a 16-bit identify word read port indexed by word number.
package identify_pkg;

    // ------------------------------------------------------------------
    // Word geometry and word numbers
    // ------------------------------------------------------------------
    localparam int         WORD_W     = 16;          // Identify word width
    localparam int         ADDR_W     = 8;           // Word number width
    localparam logic [7:0] WIDX_PIO68 = 8'h44;       // Min PIO cycle with flow control
    localparam logic [7:0] WIDX_SUP_A = 8'h52;       // Feature support word a
    localparam logic [7:0] WIDX_SUP_B = 8'h53;       // Feature support word b
    localparam logic [7:0] WIDX_SUP_C = 8'h54;       // Feature support word c
    localparam logic [7:0] WIDX_ENA_A = 8'h55;       // Feature enabled word a
    localparam logic [7:0] WIDX_ENA_B = 8'h56;       // Feature enabled word b
    localparam logic [7:0] WIDX_ENA_C = 8'h57;       // Feature enabled word c
    localparam logic [15:0] WORD_NONE = 16'h0000;    // Answer for words not held here

    // ------------------------------------------------------------------
    // Fixed bit patterns (ones; other fixed bits are zero)
    // ------------------------------------------------------------------
    localparam logic [15:0] FIX_SUP_A = 16'h7008;    // Bits 3,12,13,14
    localparam logic [15:0] FIX_SUP_B = 16'h7404;    // Bits 2,10,12,13,14
    localparam logic [15:0] FIX_SUP_C = 16'h4000;    // Bit 14 set, bit 15 clear
    localparam logic [15:0] FIX_ENA_A = 16'h7008;    // Bits 3,12,13,14
    localparam logic [15:0] FIX_ENA_B = 16'h8404;    // Bits 2,10,15
    localparam logic [15:0] FIX_ENA_C = 16'h4000;    // Bit 14 set, bit 15 clear

    // ------------------------------------------------------------------
    // Dynamic bit positions
    // ------------------------------------------------------------------
    localparam int B_SMART     = 0;                  // Smart support / enable
    localparam int B_SECURITY  = 1;                  // Security support / enable
    localparam int B_APM       = 3;                  // Advanced power management
    localparam int B_WCACHE    = 5;                  // Write cache
    localparam int B_LOOKAHEAD = 6;                  // Look-ahead
    localparam int B_GPL       = 5;                  // General purpose logging
    localparam int B_FUA       = 6;                  // Forced unit access writes
    localparam int B_FLUSH     = 12;                 // Cache flush
    localparam int B_FLUSH_EXT = 13;                 // Extended cache flush
    localparam logic FLUSH_SUPPORTED     = 1'b1;     // Cache flush always present
    localparam logic FLUSH_EXT_SUPPORTED = 1'b1;     // Extended flush always present

    // ------------------------------------------------------------------
    // PIO timing with flow control
    // ------------------------------------------------------------------
    localparam logic [2:0]  PIO_MODE_MIN68 = 3'd3;   // Lowest mode needing word 68
    localparam logic [15:0] PIO3_CYCLE_NS  = 16'h00B4; // Mode 3 cycle, ns
    localparam logic [15:0] PIO4_CYCLE_NS  = 16'h0078; // Mode 4 cycle, ns
    localparam logic [15:0] PIO5_CYCLE_NS  = 16'h0064; // Mode 5 cycle, ns
    localparam logic [15:0] PIO6_CYCLE_NS  = 16'h0050; // Mode 6 cycle, ns

    // ------------------------------------------------------------------
    // Reset, settle count and types
    // ------------------------------------------------------------------
    localparam logic [1:0] SETTLE_CYCLES = 2'd2;     // Strap synchroniser fill time

    // Capability straps, one bit each
    typedef struct packed {
        logic adv_other;                             // Another word 64..70 field is held
        logic fua;
        logic gpl;
        logic apm;
        logic lookahead;
        logic wcache;
        logic security;
        logic smart;
    } caps_s;
    localparam int CAPS_W = $bits(caps_s);

    // Host-controlled enable state
    typedef struct packed {
        logic apm;
        logic lookahead;
        logic wcache;
        logic security;
        logic smart;
    } en_s;
    localparam en_s EN_RST = '{apm: 1'b0, lookahead: 1'b1, wcache: 1'b1,
                               security: 1'b0, smart: 1'b0};

    // Feature commands from the command decoder
    typedef enum logic [3:0] {
        CMD_SMART_ON  = 4'h0,
        CMD_SMART_OFF = 4'h1,
        CMD_SEC_SET   = 4'h2,
        CMD_SEC_OFF   = 4'h3,
        CMD_WC_ON     = 4'h4,
        CMD_WC_OFF    = 4'h5,
        CMD_LA_ON     = 4'h6,
        CMD_LA_OFF    = 4'h7,
        CMD_APM_ON    = 4'h8,
        CMD_APM_OFF   = 4'h9
    } feat_cmd_e;

endpackage

// ### rtl/identify_if.sv
// Carrier between the identify top, its feature state keeper and word builder.
// Assumes all parties run on one clock and the synchronised reset.
`timescale 1ns/10ps
interface identify_if;
    import identify_pkg::*;
    caps_s       caps;        // Captured capabilities
    logic        load;        // One-cycle pulse: load persistent state
    logic        nv_smart;    // Persisted smart enable
    logic        cmd_stb;     // Feature command strobe
    feat_cmd_e   cmd;         // Feature command code
    en_s         en;          // Live enable state
    en_s         snap;        // Enable state frozen at identify time
    logic [15:0] pio68;       // Word 68 value
    logic        rd;          // Word read request
    logic [7:0]  addr;        // Word number
    logic [15:0] data;        // Word read data
    logic        ack;         // Word read answer pulse

    modport keeper (input caps, load, nv_smart, cmd_stb, cmd, output en);
    modport reader (input caps, snap, pio68, rd, addr, output data, ack);
    modport ctrl   (output caps, load, nv_smart, cmd_stb, cmd, snap, pio68, rd, addr,
                    input en, data, ack);
endinterface

// ### rtl/feature_state_keeper.sv
// Holds the host-controlled feature enables behind the enabled words.
// Assumes commands come from logic on the same clock, one per strobe.
`timescale 1ns/10ps
module feature_state_keeper
    import identify_pkg::*;
(
    input  wire logic   clk,      // System clock
    input  wire logic   rst_n,    // Synchronised reset
    identify_if.keeper  fi        // Shared carrier
);

    // ------------------------------------------------------------------
    // Enable state
    // ------------------------------------------------------------------
    en_s en_ff;
    en_s nxt_en;

    // Next state; a feature can only turn on if it exists
    always_comb begin
        nxt_en = en_ff;
        if (fi.load) begin
            nxt_en.smart = fi.nv_smart & fi.caps.smart;
        end else if (fi.cmd_stb) begin
            unique case (fi.cmd)
                CMD_SMART_ON:  nxt_en.smart     = fi.caps.smart;
                CMD_SMART_OFF: nxt_en.smart     = 1'b0;
                CMD_SEC_SET:   nxt_en.security  = fi.caps.security;
                CMD_SEC_OFF:   nxt_en.security  = 1'b0;
                CMD_WC_ON:     nxt_en.wcache    = fi.caps.wcache;
                CMD_WC_OFF:    nxt_en.wcache    = 1'b0;
                CMD_LA_ON:     nxt_en.lookahead = fi.caps.lookahead;
                CMD_LA_OFF:    nxt_en.lookahead = 1'b0;
                CMD_APM_ON:    nxt_en.apm       = fi.caps.apm;
                CMD_APM_OFF:   nxt_en.apm       = 1'b0;
                default:       nxt_en           = en_ff;  // Unknown code ignored
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_ff <= EN_RST;
        end else begin
            en_ff <= nxt_en;
        end
    end

    assign fi.en = en_ff;

endmodule

// ### rtl/identify_word_builder.sv
// Assembles the identify words held here and answers word reads.
// Assumes the enable snapshot is stable while the host reads the block.
`timescale 1ns/10ps
module identify_word_builder
    import identify_pkg::*;
(
    input  wire logic   clk,      // System clock
    input  wire logic   rst_n,    // Synchronised reset
    identify_if.reader  fi        // Shared carrier
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Places two dynamic bits over a fixed pattern
    function automatic logic [15:0] put2(input logic [15:0] base, input int pa,
                                         input logic va, input int pb, input logic vb);
        logic [15:0] w;
        w     = base;
        w[pa] = va;
        w[pb] = vb;
        return w;
    endfunction

    logic [15:0] word_nxt;    // Selected word this cycle
    logic [15:0] data_ff;     // Registered read data
    logic        ack_ff;      // Registered answer pulse

    // Word select; feature bits come from caps or snapshot, flush bits from constants
    always_comb begin
        unique case (fi.addr)
            WIDX_PIO68: word_nxt = fi.pio68;
            WIDX_SUP_A: word_nxt = put2(put2(FIX_SUP_A, B_SMART, fi.caps.smart,
                                    B_SECURITY, fi.caps.security), B_WCACHE,
                                    fi.caps.wcache, B_LOOKAHEAD, fi.caps.lookahead);
            WIDX_SUP_B: word_nxt = put2(FIX_SUP_B, B_APM, fi.caps.apm,
                                    B_FLUSH, FLUSH_SUPPORTED);
            WIDX_SUP_C: word_nxt = put2(FIX_SUP_C, B_GPL, fi.caps.gpl,
                                    B_FUA, fi.caps.fua);
            WIDX_ENA_A: word_nxt = put2(put2(FIX_ENA_A, B_SMART, fi.snap.smart,
                                    B_SECURITY, fi.snap.security), B_WCACHE,
                                    fi.snap.wcache, B_LOOKAHEAD, fi.snap.lookahead);
            WIDX_ENA_B: word_nxt = put2(put2(FIX_ENA_B, B_APM, fi.snap.apm,
                                    B_FLUSH, FLUSH_SUPPORTED), B_FLUSH_EXT,
                                    FLUSH_EXT_SUPPORTED, B_APM, fi.snap.apm);
            WIDX_ENA_C: word_nxt = put2(FIX_ENA_C, B_GPL, fi.caps.gpl,
                                    B_FUA, fi.caps.fua);
            default:    word_nxt = WORD_NONE;   // Words not held here read zero
        endcase
    end

    // Read data register, loaded only on a request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= WORD_NONE;
        end else if (fi.rd) begin
            data_ff <= word_nxt;
        end
    end

    // Answer pulse one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= fi.rd;
        end
    end

    assign fi.data = data_ff;
    assign fi.ack  = ack_ff;

endmodule

// ### rtl/identify_feature_words.sv
// Top of the identify feature words: word 68 and the support/enable words.
// Assumes capability straps and the persisted smart level come from pins,
// while feature commands and word reads come from logic on SYS_CLK.
`timescale 1ns/10ps

// What this block does
// - Word 68 gives min flow-controlled PIO cycle
// - PIO mode 3+ reports fastest mode cycle
// - Word 68 zero when only others valid
// - Support words b, c carry 01 signature
// - Support word a fixed ones and zeros
// - Support word a capability bits follow straps
// - Support word b fixed ones and zeros
// - Support word b APM bit follows capability
// - Support word c fixed bits and signature
// - Support word c logging and FUA bits
// - Smart enable host-set and kept across power
// - Security enabled after password set
// - Write cache and look-ahead show enable
// - Enabled word a fixed ones and zeros
// - Enabled word b APM after set features
// - Enabled word b 48-bit and 119/120 valid
// - Enabled word b zeros and flush bits
// - Enabled word c logging and FUA bits
// - Enabled word c zeros and signature
// - Advanced words valid flag when held
module identify_feature_words
    import identify_pkg::*;
(
    input  wire logic              SYS_CLK,        // 10 MHz system clock
    input  wire logic              NRST,           // Asynchronous reset, active low
    input  wire logic [CAPS_W-1:0] CAP_PINS,       // Capability straps
    input  wire logic [2:0]        PIO_MAX_MODE,   // Highest PIO mode strap
    input  wire logic              SMART_NV_LEVEL, // Persisted smart enable
    input  wire logic              FEAT_STB,       // Feature command strobe
    input  wire logic [3:0]        FEAT_CMD,       // Feature command code
    input  wire logic              IDENT_CMD,      // Identify command start pulse
    input  wire logic              WORD_RD,        // Word read request
    input  wire logic [ADDR_W-1:0] WORD_ADDR,      // Word number
    output logic [WORD_W-1:0]      WORD_DATA,      // Word read data
    output logic                   WORD_ACK,       // Word answer pulse
    output logic                   ADV_WORDS_VALID, // Words 64..70 valid flag
    output logic                   SMART_NV_WR,    // Write persisted smart level
    output logic                   SMART_NV_DATA,  // Level to persist
    output logic                   READY           // Straps captured, reads served
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;   // First reset stage
    logic rst_n_ff;      // Synchronised reset used everywhere

    // Asserts at once, releases after two edges to avoid recovery races
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [CAPS_W-1:0] caps_meta_ff;   // First stage, read only by second
    logic [CAPS_W-1:0] caps_sync_ff;   // Second stage
    logic [2:0]        mode_meta_ff;   // First stage
    logic [2:0]        mode_sync_ff;   // Second stage
    logic              nv_meta_ff;     // First stage
    logic              nv_sync_ff;     // Second stage

    // Two flops on every pin-level input
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            caps_meta_ff <= '0;
            caps_sync_ff <= '0;
            mode_meta_ff <= 3'h0;
            mode_sync_ff <= 3'h0;
            nv_meta_ff   <= 1'b0;
            nv_sync_ff   <= 1'b0;
        end else begin
            caps_meta_ff <= CAP_PINS;
            caps_sync_ff <= caps_meta_ff;
            mode_meta_ff <= PIO_MAX_MODE;
            mode_sync_ff <= mode_meta_ff;
            nv_meta_ff   <= SMART_NV_LEVEL;
            nv_sync_ff   <= nv_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Start-up sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} boot_e;
    boot_e      boot_ff;      // Start-up state
    logic [1:0] settle_ff;    // Cycles spent filling the synchronisers
    caps_s      caps_ff;      // Straps captured once after reset
    logic [2:0] mode_ff;      // PIO mode captured once after reset

    // Wait for the synchronisers to fill, then catch straps once
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            boot_ff   <= ST_SETTLE;
            settle_ff <= 2'h0;
        end else begin
            unique case (boot_ff)
                ST_SETTLE: begin
                    settle_ff <= settle_ff + 2'h1;
                    if (settle_ff == SETTLE_CYCLES) begin
                        boot_ff <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    boot_ff <= ST_RUN;
                end
                ST_RUN: begin
                    boot_ff <= ST_RUN;   // Straps stay fixed until next reset
                end
            endcase
        end
    end

    // Strap capture as settling ends
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            caps_ff <= '0;
            mode_ff <= 3'h0;
        end else if (settle_ff == SETTLE_CYCLES) begin
            caps_ff <= caps_s'(caps_sync_ff);
            mode_ff <= mode_sync_ff;
        end
    end

    // ------------------------------------------------------------------
    // Word 68 and the advanced-words flag
    // ------------------------------------------------------------------
    // Cycle time of the fastest mode; zero when not held
    function automatic logic [15:0] pio_cycle(input logic [2:0] mode);
        logic [15:0] t;
        unique case (mode)
            3'd3:    t = PIO3_CYCLE_NS;
            3'd4:    t = PIO4_CYCLE_NS;
            3'd5:    t = PIO5_CYCLE_NS;
            3'd6:    t = PIO6_CYCLE_NS;
            3'd7:    t = PIO6_CYCLE_NS;   // Beyond mode 6 clamps to fastest
            default: t = 16'h0000;        // Below mode 3 the field is absent
        endcase
        return t;
    endfunction

    logic        pio68_held;   // Word 68 is supported
    logic [15:0] pio68_ff;     // Word 68 value

    assign pio68_held = (mode_ff >= PIO_MODE_MIN68);

    // Registered so the read path has no long chain
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pio68_ff <= 16'h0000;
        end else if (pio68_held) begin
            pio68_ff <= pio_cycle(mode_ff);
        end else begin
            pio68_ff <= 16'h0000;
        end
    end

    logic adv_ff;   // Words 64..70 valid

    // Any held field in 64..70, word 68 included, raises the flag
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            adv_ff <= 1'b0;
        end else begin
            adv_ff <= pio68_held | caps_ff.adv_other;
        end
    end

    // ------------------------------------------------------------------
    // Submodules and carrier
    // ------------------------------------------------------------------
    identify_if fi ();

    logic running;   // Start-up finished
    assign running = (boot_ff == ST_RUN);

    assign fi.caps     = caps_ff;
    assign fi.load     = (boot_ff == ST_LOAD);
    assign fi.nv_smart = nv_sync_ff;
    assign fi.cmd_stb  = FEAT_STB & running;    // Commands before start-up dropped
    assign fi.cmd      = feat_cmd_e'(FEAT_CMD);
    assign fi.pio68    = pio68_ff;
    assign fi.rd       = WORD_RD & running;     // Reads before start-up dropped
    assign fi.addr     = WORD_ADDR;

    feature_state_keeper u_keeper (
        .clk   (SYS_CLK),
        .rst_n (rst_n_ff),
        .fi    (fi.keeper)
    );

    identify_word_builder u_builder (
        .clk   (SYS_CLK),
        .rst_n (rst_n_ff),
        .fi    (fi.reader)
    );

    // ------------------------------------------------------------------
    // Command-time snapshot
    // ------------------------------------------------------------------
    en_s snap_ff;   // Enables as they stood at identify start

    // Frozen at the identify command so one block reads consistently
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            snap_ff <= EN_RST;
        end else if (IDENT_CMD && running) begin
            snap_ff <= fi.en;
        end
    end

    assign fi.snap = snap_ff;

    // ------------------------------------------------------------------
    // Smart enable persistence
    // ------------------------------------------------------------------
    logic smart_prev_ff;   // Smart enable one cycle ago
    logic nv_wr_ff;        // Write-back pulse
    logic nv_data_ff;      // Level written back

    // Track the live level from the load onward
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            smart_prev_ff <= 1'b0;
        end else begin
            smart_prev_ff <= fi.load ? fi.nv_smart & fi.caps.smart : fi.en.smart;
        end
    end

    // Any change after start-up is written back so it survives power loss
    always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            nv_wr_ff   <= 1'b0;
            nv_data_ff <= 1'b0;
        end else begin
            nv_wr_ff   <= running && (fi.en.smart != smart_prev_ff);
            nv_data_ff <= fi.en.smart;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign WORD_DATA       = fi.data;
    assign WORD_ACK        = fi.ack;
    assign ADV_WORDS_VALID = adv_ff;
    assign SMART_NV_WR     = nv_wr_ff;
    assign SMART_NV_DATA   = nv_data_ff;
    assign READY           = running;

endmodule

// ### test/identify_feature_words_assertions.sv
// Checker for the identify feature words, watching top ports only.
// Assumes straps change only in reset.
`timescale 1ns/10ps
module identify_feature_words_assertions (
    input wire logic        SYS_CLK, NRST, WORD_RD, WORD_ACK, READY, ADV_WORDS_VALID,
    input wire logic        FEAT_STB, SMART_NV_WR, SMART_NV_DATA,
    input wire logic [7:0]  CAP_PINS, WORD_ADDR,
    input wire logic [2:0]  PIO_MAX_MODE,
    input wire logic [3:0]  FEAT_CMD,
    input wire logic [15:0] WORD_DATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic [7:0]  addr_ff; // Word number of the read now answered
    logic [15:0] cyc68;   // Expected flow-controlled cycle time
    always_ff @(posedge SYS_CLK) addr_ff <= WORD_ADDR;
    // Slow modes leave the word at zero
    always_comb case (PIO_MAX_MODE)
        3'h3: cyc68 = 16'h00B4;
        3'h4: cyc68 = 16'h0078;
        3'h5: cyc68 = 16'h0064;
        3'h6, 3'h7: cyc68 = 16'h0050;
        default: cyc68 = 16'h0000;
    endcase
    property p_ack; WORD_RD && READY |=> WORD_ACK; endproperty
    a_ack: assert property (p_ack) else $error("read not answered");
    property p_idle; !(WORD_RD && READY) |=> !WORD_ACK; endproperty
    a_idle: assert property (p_idle) else $error("answer without read");
    property p_w68; WORD_ACK && addr_ff == 8'h44 |-> WORD_DATA == cyc68; endproperty
    a_w68: assert property (p_w68) else $error("cycle time word wrong");
    property p_w82; WORD_ACK && addr_ff == 8'h52 |->
        WORD_DATA == (16'h7008 | {9'h0, CAP_PINS[3:2], 3'h0, CAP_PINS[1:0]}); endproperty
    a_w82: assert property (p_w82) else $error("support word a wrong");
    property p_w83; WORD_ACK && addr_ff == 8'h53 |->
        WORD_DATA == (16'h7404 | {12'h0, CAP_PINS[4], 3'h0}); endproperty
    a_w83: assert property (p_w83) else $error("support word b wrong");
    property p_w84; WORD_ACK && (addr_ff == 8'h54 || addr_ff == 8'h57) |->
        WORD_DATA == (16'h4000 | {9'h0, CAP_PINS[6:5], 5'h0}); endproperty
    a_w84: assert property (p_w84) else $error("word c wrong");
    property p_adv; READY[*3] |-> ADV_WORDS_VALID == (PIO_MAX_MODE > 2 || CAP_PINS[7]);
    endproperty
    a_adv: assert property (p_adv) else $error("advanced valid flag wrong");
    property p_nv; SMART_NV_WR |-> $past(FEAT_STB, 2) &&
        SMART_NV_DATA == ($past(FEAT_CMD, 2) == 4'h0); endproperty
    a_nv: assert property (p_nv) else $error("smart write-back wrong");
    c_w85: cover property (WORD_ACK && addr_ff == 8'h55);
    c_nv: cover property (SMART_NV_WR);
    c_z68: cover property (WORD_ACK && addr_ff == 8'h44 && ADV_WORDS_VALID && cyc68 == 0);
endmodule
bind identify_feature_words identify_feature_words_assertions u_chk (.SYS_CLK(SYS_CLK),
    .NRST(NRST), .WORD_RD(WORD_RD), .WORD_ACK(WORD_ACK), .READY(READY), .FEAT_STB(FEAT_STB),
    .ADV_WORDS_VALID(ADV_WORDS_VALID), .SMART_NV_WR(SMART_NV_WR), .CAP_PINS(CAP_PINS),
    .SMART_NV_DATA(SMART_NV_DATA), .WORD_ADDR(WORD_ADDR), .PIO_MAX_MODE(PIO_MAX_MODE),
    .FEAT_CMD(FEAT_CMD), .WORD_DATA(WORD_DATA));

// ### test/ata_host_model.sv
// Host model: identify start, feature commands and word reads.
// Assumes the device answers a taken read at the next edge.
`timescale 1ns/10ps
module ata_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_ack,
    output logic             ident, rd, stb, info,
    output logic [7:0]       addr,
    output logic [3:0]       cmd
);
    initial {ident, rd, stb, info, addr, cmd} = '0;
    // Idle address shows the inverse so a stale value never looks valid
    task automatic fetch(input logic [7:0] a, output logic [15:0] d, output logic k);
        @(negedge clk) {rd, addr} = {1'b1, a};
        @(negedge clk) {rd, addr, d, k} = {1'b0, ~a, rd_data, rd_ack};
        info = !(d inside {16'h0000, 16'hFFFF});
    endtask
    task automatic feat(input logic [3:0] c);
        @(negedge clk) {stb, cmd} = {1'b1, c};
        @(negedge clk) {stb, cmd} = {1'b0, ~c};
        @(negedge clk);
    endtask
    task automatic start();
        @(negedge clk) ident = 1'b1;
        @(negedge clk) ident = 1'b0;
    endtask
endmodule

// ### test/tb.sv
// Bench for the identify feature words, driven through the host model.
// Assumes one clock; straps change only while reset is held.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    logic        SYS_CLK = 0, NRST = 0, nv = 0, ident, rd, stb, ack, adv, nv_wr, nv_d, ready, k;
    logic [7:0]  caps = 0, addr;
    logic [2:0]  mode = 0;
    logic [3:0]  cmd;
    logic [15:0] data, d;
    int          fail_count = 0, checked = 0, cyc = 0;
    identify_feature_words u_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .CAP_PINS(caps),
        .PIO_MAX_MODE(mode), .SMART_NV_LEVEL(nv), .FEAT_STB(stb), .FEAT_CMD(cmd),
        .IDENT_CMD(ident), .WORD_RD(rd), .WORD_ADDR(addr), .WORD_DATA(data), .WORD_ACK(ack),
        .ADV_WORDS_VALID(adv), .SMART_NV_WR(nv_wr), .SMART_NV_DATA(nv_d), .READY(ready));
    ata_host_model u_host (.clk(SYS_CLK), .rd_data(data), .rd_ack(ack), .ident(ident),
        .rd(rd), .stb(stb), .info(), .addr(addr), .cmd(cmd));
    initial forever #50 SYS_CLK = ~SYS_CLK;
    // Run of about 400 cycles; wide margin
    always @(posedge SYS_CLK) if (++cyc == 3000) begin fail_count++; summarize(); end
    task automatic restart(input logic [7:0] c, input logic [2:0] m, input logic n);
        @(negedge SYS_CLK) {NRST, caps, mode, nv} = {1'b0, c, m, n};
        repeat (12) @(negedge SYS_CLK);
        NRST = 1'b1;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge SYS_CLK);
        `CHK("ready", 1'b1, ready)
    endtask
    // Every strap mode, each capability both ways, then an unheld word
    task automatic t_words();
        logic [7:0] wl[7] = '{8'h44, 8'h52, 8'h53, 8'h54, 8'h57, 8'h56, 8'h00};
        for (int m = 0; m < 8; m++) begin
            restart(m[0] ? 8'h7F : 8'h80, m[2:0], m[0]);
            u_host.start();
            u_host.fetch(8'h55, d, k);
            `CHK("word85", 16'h7068 | m[0], d)
            foreach (wl[i]) begin
                u_host.fetch(wl[i], d, k);
                `CHK("ack", 1'b1, k)
            end
            `CHK("unheld", 16'h0000, d)
        end
    endtask
    // Every command; words only change at the next identify
    task automatic t_feat();
        logic [3:0]  cl[2][5] = '{'{1, 2, 5, 7, 8}, '{0, 3, 4, 6, 9}};
        logic [15:0] e85[2] = '{16'h700A, 16'h7069};
        logic [15:0] e86[2] = '{16'hB40C, 16'hB404};
        restart(8'h7F, 3'h7, 1'b1);
        u_host.start();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                u_host.feat(cl[p][i]);
                `CHK("nvwr", {cl[p][i] < 2, cl[p][i] == 0}, {nv_wr, nv_wr & nv_d})
            end
            u_host.fetch(8'h55, d, k);
            `CHK("stale85", e85[!p], d)
            u_host.start();
            u_host.fetch(8'h55, d, k);
            `CHK("word85", e85[p], d)
            u_host.fetch(8'h56, d, k);
            `CHK("word86", e86[p], d)
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        t_words();
        t_feat();
        summarize();
    end
endmodule
